// ---- rtl/ata_dispatch_pkg.sv ----
package ata_dispatch_pkg;

  // Dispatch protocols
  typedef enum logic [2:0] {
    PROTO_NONE  = 3'b000,
    PROTO_NODATA = 3'b001,
    PROTO_PIO_IN = 3'b010,
    PROTO_PIO_OUT = 3'b011,
    PROTO_DMA   = 3'b100,
    PROTO_DIAG  = 3'b101
  } proto_t;

  // Command sets
  typedef enum logic [2:0] {
    SET_GENERAL  = 3'b000,
    SET_POWER    = 3'b001,
    SET_SECURITY = 3'b010,
    SET_SMART    = 3'b011,
    SET_HPA      = 3'b100,
    SET_NONE     = 3'b111
  } cmd_set_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ISSUE  = 2'b01,
    ST_BUSY   = 2'b10,
    ST_FROZEN = 2'b11
  } disp_state_t;

  // Command word from the task file
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
  } cmd_word_t;

  // Decoded dispatch result
  typedef struct packed {
    proto_t     proto;
    cmd_set_t   cmd_set;
    logic [7:0] opcode;
    logic [7:0] sub_op;
    logic       abort;
  } dispatch_t;

  // General set opcodes
  localparam logic [7:0] OP_DIAG       = 8'h90;
  localparam logic [7:0] OP_FLUSH      = 8'he7;
  localparam logic [7:0] OP_IDENTIFY   = 8'hec;
  localparam logic [7:0] OP_RD_DMA     = 8'hc8;
  localparam logic [7:0] OP_RD_MULT    = 8'hc4;
  localparam logic [7:0] OP_RD_SECT    = 8'h20;
  localparam logic [7:0] OP_RD_VFY0    = 8'h40;
  localparam logic [7:0] OP_RD_VFY1    = 8'h41;
  localparam logic [7:0] OP_SET_FEAT   = 8'hef;
  localparam logic [7:0] OP_SET_MULT   = 8'hc6;
  localparam logic [7:0] OP_WR_DMA     = 8'hca;
  localparam logic [7:0] OP_WR_MULT    = 8'hc5;
  localparam logic [7:0] OP_WR_SECT    = 8'h30;
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_RD_BUF     = 8'he4;
  localparam logic [7:0] OP_WR_BUF     = 8'he8;
  // Power management, primary and alternate
  localparam logic [7:0] OP_PM_LO      = 8'he0;
  localparam logic [7:0] OP_PM_HI      = 8'he3;
  localparam logic [7:0] OP_PM_CHK     = 8'he5;
  localparam logic [7:0] OP_PM_SLEEP   = 8'he6;
  localparam logic [7:0] OP_PM_ALT_LO  = 8'h94;
  localparam logic [7:0] OP_PM_ALT_HI  = 8'h99;
  // Security
  localparam logic [7:0] OP_SEC_PWD    = 8'hf1;
  localparam logic [7:0] OP_SEC_UNLOCK = 8'hf2;
  localparam logic [7:0] OP_SEC_EPREP  = 8'hf3;
  localparam logic [7:0] OP_SEC_ERASE  = 8'hf4;
  localparam logic [7:0] OP_SEC_FREEZE = 8'hf5;
  localparam logic [7:0] OP_SEC_DIS    = 8'hf6;
  // SMART and its sub-operation selectors
  localparam logic [7:0] OP_SMART      = 8'hb0;
  localparam logic [7:0] SM_READ_DATA  = 8'hd0;
  localparam logic [7:0] SM_AUTOSAVE   = 8'hd2;
  localparam logic [7:0] SM_OFFLINE    = 8'hd4;
  localparam logic [7:0] SM_ENABLE     = 8'hd8;
  localparam logic [7:0] SM_DISABLE    = 8'hd9;
  localparam logic [7:0] SM_STATUS     = 8'hda;
  // Host protected area and set-max selectors
  localparam logic [7:0] OP_RD_NATIVE  = 8'hf8;
  localparam logic [7:0] OP_SET_MAX    = 8'hf9;
  localparam logic [7:0] SMX_ADDR      = 8'h00;
  localparam logic [7:0] SMX_PWD       = 8'h01;
  localparam logic [7:0] SMX_LOCK      = 8'h02;
  localparam logic [7:0] SMX_UNLOCK    = 8'h03;
  localparam logic [7:0] SMX_FREEZE    = 8'h04;

endpackage : ata_dispatch_pkg

// ---- rtl/ata_command_dispatch.sv ----
`timescale 1ns/1ps

module ata_command_dispatch (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        clk_en,
  input  wire logic                        pwr_fail_pin,
  input  wire ata_dispatch_pkg::cmd_word_t cmd_in,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  output ata_dispatch_pkg::dispatch_t      disp_out,
  output logic                             disp_valid,
  input  wire logic                        disp_ready,
  input  wire logic                        disp_done,
  input  wire logic                        flash_req_in,
  output logic                             flash_req,
  output logic                             frozen,
  output logic                             busy
);

  ////////////////////////////////////////////////////////////////////////
  // Power-fail synchroniser

  logic [2:0] pf_sync_q;
  logic [2:0] pf_sync_d;
  logic       pf_level_q;
  logic       pf_level_d;

  always_comb begin
    pf_sync_d  = {pf_sync_q[1:0], pwr_fail_pin};
    pf_level_d = pf_level_q;
    if (pf_sync_q[1] == pf_sync_q[2]) begin
      pf_level_d = pf_sync_q[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pf_sync_q  <= 3'h0;
      pf_level_q <= 1'b0;
    end else if (clk_en) begin
      pf_sync_q  <= pf_sync_d;
      pf_level_q <= pf_level_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Opcode decoder

  ata_dispatch_pkg::dispatch_t dec;

  always_comb begin
    dec.opcode  = cmd_in.opcode;
    dec.sub_op  = cmd_in.feature;
    dec.abort   = 1'b0;
    dec.cmd_set = ata_dispatch_pkg::SET_GENERAL;
    dec.proto   = ata_dispatch_pkg::PROTO_NODATA;
    if ((cmd_in.opcode >= ata_dispatch_pkg::OP_PM_LO && cmd_in.opcode <= ata_dispatch_pkg::OP_PM_HI)
        || cmd_in.opcode == ata_dispatch_pkg::OP_PM_CHK || cmd_in.opcode == ata_dispatch_pkg::OP_PM_SLEEP
        || (cmd_in.opcode >= ata_dispatch_pkg::OP_PM_ALT_LO
            && cmd_in.opcode <= ata_dispatch_pkg::OP_PM_ALT_HI)) begin
      dec.cmd_set = ata_dispatch_pkg::SET_POWER;
      dec.proto   = ata_dispatch_pkg::PROTO_NODATA;
    end else begin
      case (cmd_in.opcode)
        ata_dispatch_pkg::OP_DIAG: begin
          dec.proto = ata_dispatch_pkg::PROTO_DIAG;
        end
        ata_dispatch_pkg::OP_RD_DMA, ata_dispatch_pkg::OP_WR_DMA: begin
          dec.proto = ata_dispatch_pkg::PROTO_DMA;
        end
        ata_dispatch_pkg::OP_IDENTIFY, ata_dispatch_pkg::OP_RD_SECT,
        ata_dispatch_pkg::OP_RD_MULT, ata_dispatch_pkg::OP_RD_BUF: begin
          dec.proto = ata_dispatch_pkg::PROTO_PIO_IN;
        end
        ata_dispatch_pkg::OP_WR_SECT, ata_dispatch_pkg::OP_WR_MULT,
        ata_dispatch_pkg::OP_WR_BUF: begin
          dec.proto = ata_dispatch_pkg::PROTO_PIO_OUT;
        end
        ata_dispatch_pkg::OP_FLUSH, ata_dispatch_pkg::OP_RD_VFY0, ata_dispatch_pkg::OP_RD_VFY1,
        ata_dispatch_pkg::OP_SET_FEAT, ata_dispatch_pkg::OP_SET_MULT, ata_dispatch_pkg::OP_NOP: begin
          dec.proto = ata_dispatch_pkg::PROTO_NODATA;
        end
        ata_dispatch_pkg::OP_SEC_PWD, ata_dispatch_pkg::OP_SEC_UNLOCK,
        ata_dispatch_pkg::OP_SEC_ERASE, ata_dispatch_pkg::OP_SEC_DIS: begin
          dec.cmd_set = ata_dispatch_pkg::SET_SECURITY;
          dec.proto   = ata_dispatch_pkg::PROTO_PIO_OUT;
        end
        ata_dispatch_pkg::OP_SEC_EPREP, ata_dispatch_pkg::OP_SEC_FREEZE: begin
          dec.cmd_set = ata_dispatch_pkg::SET_SECURITY;
          dec.proto   = ata_dispatch_pkg::PROTO_NODATA;
        end
        ata_dispatch_pkg::OP_SMART: begin
          dec.cmd_set = ata_dispatch_pkg::SET_SMART;
          case (cmd_in.feature)
            ata_dispatch_pkg::SM_READ_DATA: begin
              dec.proto = ata_dispatch_pkg::PROTO_PIO_IN;
            end
            ata_dispatch_pkg::SM_AUTOSAVE, ata_dispatch_pkg::SM_OFFLINE, ata_dispatch_pkg::SM_ENABLE,
            ata_dispatch_pkg::SM_DISABLE, ata_dispatch_pkg::SM_STATUS: begin
              dec.proto = ata_dispatch_pkg::PROTO_NODATA;
            end
            default: begin
              dec.proto = ata_dispatch_pkg::PROTO_NONE;
              dec.abort = 1'b1;
            end
          endcase
        end
        ata_dispatch_pkg::OP_RD_NATIVE: begin
          dec.cmd_set = ata_dispatch_pkg::SET_HPA;
          dec.proto   = ata_dispatch_pkg::PROTO_NODATA;
        end
        ata_dispatch_pkg::OP_SET_MAX: begin
          dec.cmd_set = ata_dispatch_pkg::SET_HPA;
          case (cmd_in.feature)
            ata_dispatch_pkg::SMX_ADDR, ata_dispatch_pkg::SMX_LOCK, ata_dispatch_pkg::SMX_FREEZE: begin
              dec.proto = ata_dispatch_pkg::PROTO_NODATA;
            end
            ata_dispatch_pkg::SMX_PWD, ata_dispatch_pkg::SMX_UNLOCK: begin
              dec.proto = ata_dispatch_pkg::PROTO_PIO_OUT;
            end
            default: begin
              dec.proto = ata_dispatch_pkg::PROTO_NONE;
              dec.abort = 1'b1;
            end
          endcase
        end
        default: begin
          dec.cmd_set = ata_dispatch_pkg::SET_NONE;
          dec.proto   = ata_dispatch_pkg::PROTO_NONE;
          dec.abort   = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dispatch state machine

  ata_dispatch_pkg::disp_state_t state_q;
  ata_dispatch_pkg::disp_state_t state_d;
  ata_dispatch_pkg::dispatch_t   disp_q;
  ata_dispatch_pkg::dispatch_t   disp_d;

  always_comb begin
    state_d = state_q;
    disp_d  = disp_q;
    if (pf_level_q) begin
      state_d = ata_dispatch_pkg::ST_FROZEN;
    end else begin
      case (state_q)
        ata_dispatch_pkg::ST_IDLE: begin
          if (cmd_valid) begin
            disp_d  = dec;
            state_d = ata_dispatch_pkg::ST_ISSUE;
          end
        end
        ata_dispatch_pkg::ST_ISSUE: begin
          if (disp_ready) begin
            state_d = disp_q.abort ? ata_dispatch_pkg::ST_IDLE : ata_dispatch_pkg::ST_BUSY;
          end
        end
        ata_dispatch_pkg::ST_BUSY: begin
          if (disp_done) begin
            state_d = ata_dispatch_pkg::ST_IDLE;
          end
        end
        ata_dispatch_pkg::ST_FROZEN: begin
          state_d = ata_dispatch_pkg::ST_FROZEN;
        end
        default: begin
          state_d = ata_dispatch_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ata_dispatch_pkg::ST_IDLE;
      disp_q  <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      disp_q  <= disp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign frozen     = (state_q == ata_dispatch_pkg::ST_FROZEN);
  assign cmd_ready  = (state_q == ata_dispatch_pkg::ST_IDLE) && !pf_level_q;
  assign disp_valid = (state_q == ata_dispatch_pkg::ST_ISSUE) && !pf_level_q;
  assign disp_out   = disp_q;
  assign busy       = (state_q == ata_dispatch_pkg::ST_ISSUE) || (state_q == ata_dispatch_pkg::ST_BUSY);
  assign flash_req  = flash_req_in && !frozen && !pf_level_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_dma_route;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && state_q == ata_dispatch_pkg::ST_IDLE && cmd_valid && !pf_level_q
       && (cmd_in.opcode == ata_dispatch_pkg::OP_RD_DMA || cmd_in.opcode == ata_dispatch_pkg::OP_WR_DMA))
      |=> (disp_valid == !pf_level_q) && disp_out.proto == ata_dispatch_pkg::PROTO_DMA;
  endproperty
  a_dma_route: assert property (p_dma_route) else $error("DMA opcode misrouted");

  property p_power_nodata;
    @(posedge clk_sys) disable iff (rst)
      (disp_valid && disp_out.cmd_set == ata_dispatch_pkg::SET_POWER)
      |-> disp_out.proto == ata_dispatch_pkg::PROTO_NODATA;
  endproperty
  a_power_nodata: assert property (p_power_nodata) else $error("Power command not non-data");

  property p_smart_read;
    @(posedge clk_sys) disable iff (rst)
      (disp_valid && disp_out.opcode == ata_dispatch_pkg::OP_SMART
       && disp_out.sub_op == ata_dispatch_pkg::SM_READ_DATA)
      |-> disp_out.proto == ata_dispatch_pkg::PROTO_PIO_IN;
  endproperty
  a_smart_read: assert property (p_smart_read) else $error("SMART read not PIO in");

  property p_native_max;
    @(posedge clk_sys) disable iff (rst)
      (disp_valid && disp_out.opcode == ata_dispatch_pkg::OP_RD_NATIVE)
      |-> disp_out.proto == ata_dispatch_pkg::PROTO_NODATA && !disp_out.abort;
  endproperty
  a_native_max: assert property (p_native_max) else $error("Native max misrouted");

  property p_freeze_entry;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && pf_level_q) |=> frozen && !cmd_ready [*2];
  endproperty
  a_freeze_entry: assert property (p_freeze_entry) else $error("Power fail did not freeze");

  property p_flash_quiet;
    @(posedge clk_sys) disable iff (rst)
      frozen |-> !flash_req;
  endproperty
  a_flash_quiet: assert property (p_flash_quiet) else $error("Flash request while frozen");

  property p_security_out;
    @(posedge clk_sys) disable iff (rst)
      (disp_valid && (disp_out.opcode == ata_dispatch_pkg::OP_SEC_ERASE
                      || disp_out.opcode == ata_dispatch_pkg::OP_SEC_DIS))
      |-> disp_out.proto == ata_dispatch_pkg::PROTO_PIO_OUT;
  endproperty
  a_security_out: assert property (p_security_out) else $error("Security write misrouted");

  property p_security_nd;
    @(posedge clk_sys) disable iff (rst)
      (disp_valid && disp_out.opcode == ata_dispatch_pkg::OP_SEC_FREEZE)
      |-> disp_out.proto == ata_dispatch_pkg::PROTO_NODATA;
  endproperty
  a_security_nd: assert property (p_security_nd) else $error("Freeze lock not non-data");

endmodule : ata_command_dispatch

// ---- sim/proto_engine_model.sv ----
`timescale 1ns/1ps

module proto_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       disp_valid,
  input  wire logic       abort,
  input  wire logic [3:0] lat,
  output logic            disp_ready,
  output logic            disp_done
);
  // Accept after lat cycles, finish after lat more unless abort is set
  initial begin
    disp_ready = 1'b0;
    disp_done  = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (disp_valid === 1'b1 && rst === 1'b0) begin
        repeat (lat) @(negedge clk_sys);
        disp_ready = 1'b1;
        @(negedge clk_sys);
        disp_ready = 1'b0;
        if (abort !== 1'b1) begin
          repeat (lat) @(negedge clk_sys);
          disp_done = 1'b1;
          @(negedge clk_sys);
          disp_done = 1'b0;
        end
      end
    end
  end
endmodule : proto_engine_model

// ---- sim/ata_command_dispatch_bench.sv ----
`timescale 1ns/1ps

module ata_command_dispatch_bench;
  typedef struct packed {
    logic [7:0]                 op;
    logic [7:0]                 ft;
    ata_dispatch_pkg::proto_t   pr;
    ata_dispatch_pkg::cmd_set_t st;
  } row_t;
  localparam ata_dispatch_pkg::proto_t   ND = ata_dispatch_pkg::PROTO_NODATA;
  localparam ata_dispatch_pkg::proto_t   PI = ata_dispatch_pkg::PROTO_PIO_IN;
  localparam ata_dispatch_pkg::proto_t   PO = ata_dispatch_pkg::PROTO_PIO_OUT;
  localparam ata_dispatch_pkg::proto_t   DM = ata_dispatch_pkg::PROTO_DMA;
  localparam ata_dispatch_pkg::proto_t   DG = ata_dispatch_pkg::PROTO_DIAG;
  localparam ata_dispatch_pkg::proto_t   NO = ata_dispatch_pkg::PROTO_NONE;
  localparam ata_dispatch_pkg::cmd_set_t G  = ata_dispatch_pkg::SET_GENERAL;
  localparam ata_dispatch_pkg::cmd_set_t P  = ata_dispatch_pkg::SET_POWER;
  localparam ata_dispatch_pkg::cmd_set_t S  = ata_dispatch_pkg::SET_SECURITY;
  localparam ata_dispatch_pkg::cmd_set_t M  = ata_dispatch_pkg::SET_SMART;
  localparam ata_dispatch_pkg::cmd_set_t H  = ata_dispatch_pkg::SET_HPA;
  localparam ata_dispatch_pkg::cmd_set_t X  = ata_dispatch_pkg::SET_NONE;

  logic                        clk_sys;
  logic                        rst;
  logic                        clk_en;
  logic                        pwr_fail_pin;
  ata_dispatch_pkg::cmd_word_t cmd_in;
  logic                        cmd_valid;
  logic                        cmd_ready;
  ata_dispatch_pkg::dispatch_t disp_out;
  logic                        disp_valid;
  logic                        disp_ready;
  logic                        disp_done;
  logic                        flash_req_in;
  logic                        flash_req;
  logic                        frozen;
  logic                        busy;
  logic [3:0]                  lat;
  int                          error_cnt;
  int                          n_compared;
  row_t                        rows[$];

  ata_command_dispatch i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .pwr_fail_pin(pwr_fail_pin),
    .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .disp_out(disp_out),
    .disp_valid(disp_valid), .disp_ready(disp_ready), .disp_done(disp_done),
    .flash_req_in(flash_req_in), .flash_req(flash_req), .frozen(frozen), .busy(busy));

  proto_engine_model i_engine (.clk_sys(clk_sys), .rst(rst), .disp_valid(disp_valid),
    .abort(disp_out.abort), .lat(lat), .disp_ready(disp_ready), .disp_done(disp_done));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic row_t r(logic [7:0] o, logic [7:0] f, ata_dispatch_pkg::proto_t p,
                             ata_dispatch_pkg::cmd_set_t s);
    r = '{o, f, p, s};
  endfunction : r

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic wait_idle();
    int k;
    for (k = 0; k < 40 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
    if (k == 40) begin
      error_cnt++;
      end_sim();
    end
  endtask : wait_idle

  task automatic issue(logic [7:0] o, logic [7:0] f);
    wait_idle();
    cmd_in    = '{o, f};
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic reset_chk();
    rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    cmp("cmd_ready", 8'h01, {7'h0, cmd_ready});
    cmp("frozen", 8'h00, {7'h0, frozen});
    cmp("busy", 8'h00, {7'h0, busy});
    cmp("disp_out", 8'h01, {7'h0, disp_out === '0});
  endtask : reset_chk

  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    clk_en = 1'b1;
    pwr_fail_pin = 1'b0;
    cmd_in = '0;
    cmd_valid = 1'b0;
    flash_req_in = 1'b1;
    lat = 4'h0;
    rows = '{r(8'h90,8'h00,DG,G), r(8'he7,8'h00,ND,G), r(8'hec,8'h00,PI,G), r(8'hc8,8'h00,DM,G),
      r(8'hc4,8'h00,PI,G), r(8'h20,8'h00,PI,G), r(8'h40,8'h00,ND,G), r(8'h41,8'h00,ND,G),
      r(8'hef,8'h00,ND,G), r(8'hc6,8'h00,ND,G), r(8'hca,8'h00,DM,G), r(8'hc5,8'h00,PO,G),
      r(8'h30,8'h00,PO,G), r(8'h00,8'h00,ND,G), r(8'he4,8'h00,PI,G), r(8'he8,8'h00,PO,G),
      r(8'he0,8'h00,ND,P), r(8'he1,8'h00,ND,P), r(8'he2,8'h00,ND,P), r(8'he3,8'h00,ND,P),
      r(8'he5,8'h00,ND,P), r(8'he6,8'h00,ND,P), r(8'h94,8'h00,ND,P), r(8'h95,8'h00,ND,P),
      r(8'h96,8'h00,ND,P), r(8'h97,8'h00,ND,P), r(8'h98,8'h00,ND,P), r(8'h99,8'h00,ND,P),
      r(8'hf1,8'h00,PO,S), r(8'hf2,8'h00,PO,S), r(8'hf3,8'h00,ND,S), r(8'hf4,8'h00,PO,S),
      r(8'hf5,8'h00,ND,S), r(8'hf6,8'h00,PO,S), r(8'hb0,8'hd0,PI,M), r(8'hb0,8'hd2,ND,M),
      r(8'hb0,8'hd4,ND,M), r(8'hb0,8'hd8,ND,M), r(8'hb0,8'hd9,ND,M), r(8'hb0,8'hda,ND,M),
      r(8'hf8,8'h00,ND,H), r(8'hf9,8'h00,ND,H), r(8'hf9,8'h01,PO,H), r(8'hf9,8'h02,ND,H),
      r(8'hf9,8'h03,PO,H), r(8'hf9,8'h04,ND,H), r(8'hb0,8'h55,NO,X), r(8'hf9,8'h07,NO,X),
      r(8'h93,8'h00,NO,X), r(8'h9a,8'h00,NO,X), r(8'hff,8'h00,NO,X)};
    @(negedge clk_sys);
    reset_chk();
    cmp("flash_req", 8'h01, {7'h0, flash_req});
    foreach (rows[i]) begin
      lat = i[0] ? 4'h3 : 4'h0;
      issue(rows[i].op, rows[i].ft);
      cmp("disp_valid", 8'h01, {7'h0, disp_valid});
      cmp("busy", 8'h01, {7'h0, busy});
      cmp("proto", {5'h0, rows[i].pr}, {5'h0, disp_out.proto});
      cmp("abort", {7'h0, rows[i].pr == NO}, {7'h0, disp_out.abort});
      if (rows[i].pr != NO)
        cmp("cmd_set", {5'h0, rows[i].st}, {5'h0, disp_out.cmd_set});
      cmp("opcode", rows[i].op, disp_out.opcode);
      cmp("sub_op", rows[i].ft, disp_out.sub_op);
    end
    // Held command while the clock enable is low
    wait_idle();
    clk_en = 1'b0;
    cmd_in = '{ata_dispatch_pkg::OP_NOP, 8'h00};
    cmd_valid = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp("disp_valid", 8'h00, {7'h0, disp_valid});
    clk_en = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    @(negedge clk_sys);
    cmp("proto", {5'h0, ND}, {5'h0, disp_out.proto});
    // Power fail while a dispatch stands
    lat = 4'h8;
    issue(ata_dispatch_pkg::OP_RD_DMA, 8'h00);
    pwr_fail_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    cmp("frozen", 8'h01, {7'h0, frozen});
    cmp("disp_valid", 8'h00, {7'h0, disp_valid});
    cmp("cmd_ready", 8'h00, {7'h0, cmd_ready});
    cmp("flash_req", 8'h00, {7'h0, flash_req});
    cmd_valid = 1'b1;
    pwr_fail_pin = 1'b0;
    repeat (6) @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmp("disp_valid", 8'h00, {7'h0, disp_valid});
    cmp("frozen", 8'h01, {7'h0, frozen});
    cmp("flash_req", 8'h00, {7'h0, flash_req});
    repeat (8) @(negedge clk_sys);
    reset_chk();
    flash_req_in = 1'b0;
    @(negedge clk_sys);
    cmp("flash_req", 8'h00, {7'h0, flash_req});
    end_sim();
  end
endmodule : ata_command_dispatch_bench
